// *** src/tmfc_top.sv ***
// Added by the designer: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module tmfc_top
  import tmfc_pkg::*;
(
  input wire logic clk_sys_i, // 40 MHz system clock
  input wire logic rst_n_i, // sync reset, active low
  input wire logic standby_i, // standby entry, same clock
  input tmfc_pkg::tmfc_bus_req_t bus_req_i, // register port request
  output logic [7:0] bus_rdata_o, // read data, cycle after read
  input wire logic quad_input_a_i, // quadrature pin A, async
  input wire logic quad_input_b_i, // quadrature pin B, async
  input wire logic count_tick_i, // prescaled or edge tick, normal mode
  input wire logic ch2_run_i, // channel 2 counter started
  input wire logic ch2_clear_i, // channel 2 counter clear request
  input wire logic [4:0] match_a_i, // compare match with register A
  input wire logic [4:0] match_b_i, // compare match with register B
  input wire logic ch34_running_i, // channels 3 or 4 counting
  input wire logic sync_ch3_i, // channel 3 sync bit
  input wire logic sync_ch4_i, // channel 4 sync bit
  output logic [4:0] pwm_pin_o, // A-side compare pin levels
  output tmfc_pkg::tmfc_chan_cfg_t cfg_o, // decoded channel configuration
  output logic [15:0] channel2_counter_o, // channel 2 counter value
  output logic count_dir_o, // last step direction, 1 down
  output logic irq_o // level interrupt
);

  import tmfc_pkg::*;

  logic init;
  tmfc_mode_t timer_mode_select;
  tmfc_func_t timer_function_control;
  logic [3:0] status;
  logic [3:0] mask;
  logic [3:0] next_status;
  logic [3:0] next_mask;
  logic [3:0] events;
  logic [1:0] quad_meta;
  logic [1:0] quad_sync;
  tmfc_quad_step_t step;
  logic [15:0] counter;
  logic cnt_up;
  logic cnt_dn;
  logic overflow;
  logic underflow;
  logic wrap_event;
  tmfc_comb_t comb;
  logic [4:0] pwm_eff;
  logic [4:0] pwm_pin;
  tmfc_chan_cfg_t next_cfg;
  logic wr_mode;
  logic wr_func;
  logic wr_mask;
  logic rd_stat;

  // standby has the same effect on configuration as reset
  assign init = !rst_n_i || standby_i;

  assign wr_mode = bus_req_i.wr && (bus_req_i.addr == TMFC_OFF_MODE);
  assign wr_func = bus_req_i.wr && (bus_req_i.addr == TMFC_OFF_FUNC);
  assign wr_mask = bus_req_i.wr && (bus_req_i.addr == TMFC_OFF_MASK);
  assign rd_stat = bus_req_i.rd && (bus_req_i.addr == TMFC_OFF_STAT);

  // combined modes of channels 3 and 4 take over from their own pwm bits
  function automatic logic comb_takes_over(input tmfc_comb_t c);
    logic r;
    r = 1'b0;
    case (c)
      TMFC_COMB_COMP: r = 1'b1;
      TMFC_COMB_RSYNC: r = 1'b1;
      TMFC_COMB_NORM: r = 1'b0;
      TMFC_COMB_NORM_ALT: r = 1'b0;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  assign comb = tmfc_comb_t'({timer_function_control.combination_sel_hi,
                              timer_function_control.combination_sel_lo});

  // mode register; bit seven keeps whatever software wrote
  always_ff @(posedge clk_sys_i) begin
    if (init) begin
      timer_mode_select <= tmfc_mode_t'(TMFC_MODE_RST);
    end else if (wr_mode) begin
      timer_mode_select <= tmfc_mode_t'(bus_req_i.wdata);
    end
  end

  // function register; bit six is forced so it can never read back zero
  always_ff @(posedge clk_sys_i) begin
    if (init) begin
      timer_function_control <= tmfc_func_t'(TMFC_FUNC_RST);
    end else if (wr_func) begin
      timer_function_control <= tmfc_func_t'({bus_req_i.wdata[TMFC_RSVD_BIT], 1'b1,
                                              bus_req_i.wdata[TMFC_FUNC_COMB_HI_BIT:0]});
    end
  end

  // two-stage synchronisers for the quadrature pins
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      quad_meta <= 2'h0;
      quad_sync <= 2'h0;
    end else begin
      quad_meta <= {quad_input_a_i, quad_input_b_i};
      quad_sync <= quad_meta;
    end
  end

  tmfc_quad_decoder u_quad (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .init_i(standby_i),
    .pins_i(quad_sync),
    .step_o(step)
  );

  // pick the count source for channel 2
  always_comb begin
    cnt_up = 1'b0;
    cnt_dn = 1'b0;
    if (ch2_run_i && !ch2_clear_i) begin
      if (timer_mode_select.phase_count_select) begin
        cnt_up = step.up;
        cnt_dn = step.down;
      end else begin
        cnt_up = count_tick_i;
      end
    end
  end

  assign overflow = cnt_up && (counter == TMFC_CNT_MAX);
  assign underflow = cnt_dn && (counter == TMFC_CNT_RST);
  // flag direction only matters in phase count mode, the only source of down steps
  assign wrap_event = overflow || (underflow && !timer_mode_select.flag_direction);

  // clear request works in both modes and beats a count step
  always_ff @(posedge clk_sys_i) begin
    if (init) begin
      counter <= TMFC_CNT_RST;
    end else if (ch2_clear_i) begin
      counter <= TMFC_CNT_RST;
    end else if (cnt_up) begin
      counter <= counter + TMFC_CNT_ONE;
    end else if (cnt_dn) begin
      counter <= counter - TMFC_CNT_ONE;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (init) begin
      count_dir_o <= 1'b0;
    end else if (cnt_up) begin
      count_dir_o <= 1'b0;
    end else if (cnt_dn) begin
      count_dir_o <= 1'b1;
    end
  end

  assign channel2_counter_o = counter;

  // event sources for the sticky status bits
  always_comb begin
    events = '0;
    events[TMFC_STAT_WRAP] = wrap_event;
    events[TMFC_STAT_QERR] = step.err && timer_mode_select.phase_count_select;
    // write accepted anyway; flag only warns software
    events[TMFC_STAT_COMB_BUSY] = wr_func && ch34_running_i &&
                                  bus_req_i.wdata[TMFC_FUNC_COMB_HI_BIT];
    events[TMFC_STAT_SYNC_CONFLICT] = (comb == TMFC_COMB_COMP) &&
                                      sync_ch3_i && sync_ch4_i;
  end

  // read clears, but an event in the same cycle survives
  always_comb begin
    next_status = status;
    if (rd_stat) begin
      next_status = '0;
    end
    next_status = next_status | events;
    next_mask = mask;
    if (wr_mask) begin
      next_mask = bus_req_i.wdata[TMFC_STAT_W-1:0];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (init) begin
      status <= TMFC_STAT_RST;
      mask <= TMFC_MASK_RST;
    end else begin
      status <= next_status;
      mask <= next_mask;
    end
  end

  // computed from next values so the line follows status without lag
  always_ff @(posedge clk_sys_i) begin
    if (init) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(next_status & next_mask);
    end
  end

  // read data stand for exactly one cycle; unmapped reads give zero
  always_ff @(posedge clk_sys_i) begin
    if (init) begin
      bus_rdata_o <= TMFC_RDATA_RST;
    end else if (bus_req_i.rd) begin
      case (bus_req_i.addr)
        TMFC_OFF_MODE: bus_rdata_o <= timer_mode_select;
        TMFC_OFF_FUNC: bus_rdata_o <= timer_function_control;
        TMFC_OFF_STAT: bus_rdata_o <= {4'h0, status};
        TMFC_OFF_MASK: bus_rdata_o <= {4'h0, mask};
        TMFC_OFF_CNT_LO: bus_rdata_o <= counter[7:0];
        TMFC_OFF_CNT_HI: bus_rdata_o <= counter[15:8];
        default: bus_rdata_o <= TMFC_RDATA_RST;
      endcase
    end else begin
      bus_rdata_o <= TMFC_RDATA_RST;
    end
  end

  // which channels really run single pwm
  always_comb begin
    pwm_eff = '0;
    for (int ch = 0; ch < TMFC_NUM_CH; ch++) begin
      pwm_eff[ch] = timer_mode_select.pwm_mode[ch];
      if ((ch >= TMFC_FIRST_COMB_CH) && comb_takes_over(comb)) begin
        pwm_eff[ch] = 1'b0;
      end
    end
  end

  // match B wins a tie, so equal registers give a flat low output
  for (genvar ch = 0; ch < TMFC_NUM_CH; ch++) begin : g_pwm
    always_ff @(posedge clk_sys_i) begin
      if (init) begin
        pwm_pin[ch] <= 1'b0;
      end else if (!pwm_eff[ch]) begin
        pwm_pin[ch] <= 1'b0;
      end else if (match_b_i[ch]) begin
        pwm_pin[ch] <= 1'b0;
      end else if (match_a_i[ch]) begin
        pwm_pin[ch] <= 1'b1;
      end
    end
  end

  assign pwm_pin_o = pwm_pin;

  // decoded configuration seen by the counters and pin logic
  always_comb begin
    next_cfg = '0;
    next_cfg.pwm_active = pwm_eff;
    next_cfg.comp_pwm = (comb == TMFC_COMB_COMP);
    next_cfg.reset_sync_pwm = (comb == TMFC_COMB_RSYNC);
    next_cfg.buffer_en = {timer_function_control.buffer_en_ch4_b,
                          timer_function_control.buffer_en_ch4_a,
                          timer_function_control.buffer_en_ch3_b,
                          timer_function_control.buffer_en_ch3_a};
    next_cfg.phase_count = timer_mode_select.phase_count_select;
    next_cfg.ovf_on_overflow_only = timer_mode_select.flag_direction;
  end

  always_ff @(posedge clk_sys_i) begin
    if (init) begin
      cfg_o <= '0;
    end else begin
      cfg_o <= next_cfg;
    end
  end

endmodule

// *** src/tmfc_pkg.sv ***
package tmfc_pkg;

  // register port geometry
  localparam int unsigned TMFC_ADDR_W = 3;
  localparam int unsigned TMFC_DATA_W = 8;
  localparam int unsigned TMFC_CNT_W = 16;
  localparam int unsigned TMFC_NUM_CH = 5;
  localparam int unsigned TMFC_STAT_W = 4;

  // register offsets on the plain port
  localparam logic [2:0] TMFC_OFF_MODE = 3'h0;
  localparam logic [2:0] TMFC_OFF_FUNC = 3'h1;
  localparam logic [2:0] TMFC_OFF_STAT = 3'h2;
  localparam logic [2:0] TMFC_OFF_MASK = 3'h3;
  localparam logic [2:0] TMFC_OFF_CNT_LO = 3'h4;
  localparam logic [2:0] TMFC_OFF_CNT_HI = 3'h5;

  // field positions and first combined channel
  localparam int unsigned TMFC_RSVD_BIT = 7;
  localparam int unsigned TMFC_MODE_PHASE_BIT = 6;
  localparam int unsigned TMFC_MODE_FLAG_DIRECTION_BIT = 5;
  localparam int unsigned TMFC_MODE_PWM_LSB = 0;
  localparam int unsigned TMFC_FUNC_ONE_BIT = 6;
  localparam int unsigned TMFC_FUNC_COMB_HI_BIT = 5;
  localparam int unsigned TMFC_FUNC_BUF_LSB = 0;
  localparam int unsigned TMFC_FIRST_COMB_CH = 3;

  // status bit positions
  localparam int unsigned TMFC_STAT_WRAP = 0;
  localparam int unsigned TMFC_STAT_QERR = 1;
  localparam int unsigned TMFC_STAT_COMB_BUSY = 2;
  localparam int unsigned TMFC_STAT_SYNC_CONFLICT = 3;

  // reset values and counter constants
  localparam logic [7:0] TMFC_MODE_RST = 8'h00;
  localparam logic [7:0] TMFC_FUNC_RST = 8'h40;
  localparam logic [3:0] TMFC_STAT_RST = 4'h0;
  localparam logic [3:0] TMFC_MASK_RST = 4'h0;
  localparam logic [7:0] TMFC_RDATA_RST = 8'h00;
  localparam logic [15:0] TMFC_CNT_RST = 16'h0000;
  localparam logic [15:0] TMFC_CNT_MAX = 16'hFFFF;
  localparam logic [15:0] TMFC_CNT_ONE = 16'h0001;

  typedef enum logic [1:0] {
    TMFC_COMB_NORM = 2'b00,
    TMFC_COMB_NORM_ALT = 2'b01,
    TMFC_COMB_COMP = 2'b10,
    TMFC_COMB_RSYNC = 2'b11
  } tmfc_comb_t;

  typedef struct packed {
    logic rsvd;
    logic phase_count_select;
    logic flag_direction;
    logic [4:0] pwm_mode;
  } tmfc_mode_t;

  typedef struct packed {
    logic rsvd;
    logic keep_one;
    logic combination_sel_hi;
    logic combination_sel_lo;
    logic buffer_en_ch4_b;
    logic buffer_en_ch4_a;
    logic buffer_en_ch3_b;
    logic buffer_en_ch3_a;
  } tmfc_func_t;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } tmfc_bus_req_t;

  typedef struct packed {
    logic [4:0] pwm_active;
    logic comp_pwm;
    logic reset_sync_pwm;
    logic [3:0] buffer_en;
    logic phase_count;
    logic ovf_on_overflow_only;
  } tmfc_chan_cfg_t;

  typedef struct packed {
    logic up;
    logic down;
    logic err;
  } tmfc_quad_step_t;

endpackage

// *** src/tmfc_quad_decoder.sv ***
`timescale 1ns/1ps
module tmfc_quad_decoder
  import tmfc_pkg::*;
(
  input wire logic clk_sys_i, // system clock
  input wire logic rst_n_i, // sync reset, active low
  input wire logic init_i, // standby entry only; reset comes on rst_n_i
  input wire logic [1:0] pins_i, // synchronised {a, b}
  output tmfc_pkg::tmfc_quad_step_t step_o // one-cycle step pulses
);

  logic [1:0] prev;
  logic primed;

  function automatic tmfc_quad_step_t quad_decode(input logic [1:0] p, input logic [1:0] c);
    tmfc_quad_step_t s;
    s = '0;
    case ({p, c})
      4'h7, 4'hE, 4'h8, 4'h1: s.up = 1'b1;
      4'h2, 4'hB, 4'hD, 4'h4: s.down = 1'b1;
      4'h3, 4'hC, 4'h6, 4'h9: s.err = 1'b1;
      default: s = '0;
    endcase
    return s;
  endfunction

  // first sample after init only seeds history, so no false step
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || init_i) begin
      prev <= 2'h0;
      primed <= 1'b0;
    end else begin
      prev <= pins_i;
      primed <= 1'b1;
    end
  end

  always_comb begin
    step_o = '0;
    if (primed) begin
      step_o = quad_decode(prev, pins_i);
    end
  end

endmodule

// *** testbench/tmfc_assertions.sv ***
`timescale 1ns/1ps
module tmfc_assertions
  import tmfc_pkg::*;
(
  input wire logic clk_sys_i, // clock
  input wire logic rst_n_i, // reset
  input wire logic standby_i, // standby
  input tmfc_pkg::tmfc_bus_req_t bus_req_i, // register request
  input wire logic [7:0] bus_rdata_o, // read data
  input wire logic count_tick_i, // tick
  input wire logic ch2_run_i, // run
  input wire logic ch2_clear_i, // clear
  input wire logic [4:0] match_a_i, // match A
  input wire logic [4:0] match_b_i, // match B
  input wire logic [4:0] pwm_pin_o, // pwm pins
  input tmfc_pkg::tmfc_chan_cfg_t cfg_o, // config
  input wire logic [15:0] channel2_counter_o // counter
);
  logic [7:0] wd;
  assign wd = bus_req_i.wdata;
  default clocking @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i || standby_i);
  sequence mode_wr;
    bus_req_i.wr && bus_req_i.addr == TMFC_OFF_MODE;
  endsequence
  sequence func_wr;
    bus_req_i.wr && bus_req_i.addr == TMFC_OFF_FUNC;
  endsequence
  phase_sel_a: assert property (
    mode_wr |-> ##2 cfg_o.phase_count == $past(wd[6], 2)
      && cfg_o.ovf_on_overflow_only == $past(wd[5], 2))
    else $error("phase or flag select wrong");
  pwm_enable_a: assert property (
    mode_wr |-> ##2 cfg_o.pwm_active[2:0] == $past(wd[2:0], 2))
    else $error("pwm enable wrong");
  comb_decode_a: assert property (
    func_wr |-> ##2 cfg_o.comp_pwm == $past(wd[5] & ~wd[4], 2)
      && cfg_o.reset_sync_pwm == $past(wd[5] & wd[4], 2))
    else $error("combination decode wrong");
  buf_enable_a: assert property (
    func_wr |-> ##2 cfg_o.buffer_en == $past(wd[3:0], 2))
    else $error("buffer enable wrong");
  comb_override_a: assert property (
    (cfg_o.comp_pwm || cfg_o.reset_sync_pwm) |-> cfg_o.pwm_active[4:3] == 2'b00)
    else $error("pwm bits not overridden");
  pwm_set_a: assert property (
    cfg_o.pwm_active[0] && match_a_i[0] && !match_b_i[0] |=> pwm_pin_o[0])
    else $error("pwm pin not set");
  pwm_clear_a: assert property (
    match_b_i[0] |=> !pwm_pin_o[0])
    else $error("pwm pin not cleared");
  tick_count_a: assert property (
    ch2_run_i && count_tick_i && !ch2_clear_i && !cfg_o.phase_count && !$past(bus_req_i.wr)
      |=> channel2_counter_o == $past(channel2_counter_o) + 16'h0001)
    else $error("tick count wrong");
  counter_clear_a: assert property (
    ch2_clear_i |=> channel2_counter_o == 16'h0000)
    else $error("counter not cleared");
  func_one_a: assert property (
    bus_req_i.rd && bus_req_i.addr == TMFC_OFF_FUNC |=> bus_rdata_o[6])
    else $error("function bit six not one");
  standby_init_a: assert property (
    disable iff (!rst_n_i) standby_i |=> cfg_o == '0 && channel2_counter_o == 16'h0000)
    else $error("standby did not initialise");
endmodule

// *** testbench/tmfc_encoder_model.sv ***
`timescale 1ns/1ps
module tmfc_encoder_model (
  input wire logic clk_sys_i, // step timing
  input wire logic up_i, // forward step
  input wire logic dn_i, // backward step
  output logic quad_a_o, // phase A pin
  output logic quad_b_o // phase B pin
);
  // gray position, forward walks 00 01 11 10
  logic [1:0] pos = 2'b00;
  always @(posedge clk_sys_i) begin
    if (up_i)
      pos <= pos + 2'b01;
    else if (dn_i)
      pos <= pos - 2'b01;
  end
  // one pin moves per step, never both at once
  assign quad_a_o = pos[1];
  assign quad_b_o = pos[1] ^ pos[0];
endmodule

// *** testbench/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  import tmfc_pkg::*;
  logic clk_sys_i = 1'b0, rst_n_i = 1'b0, standby_i = 1'b0, count_tick_i = 1'b0;
  logic ch2_run_i = 1'b0, ch2_clear_i = 1'b0, step_up = 1'b0, step_dn = 1'b0;
  logic ch34_running_i = 1'b0, sync_ch3_i = 1'b0, sync_ch4_i = 1'b0;
  logic [4:0] match_a_i = 5'h00, match_b_i = 5'h00, pwm_pin_o;
  tmfc_bus_req_t bus_req_i = '0;
  tmfc_chan_cfg_t cfg_o;
  logic quad_input_a_i, quad_input_b_i, count_dir_o, irq_o;
  logic [7:0] bus_rdata_o;
  logic [15:0] channel2_counter_o;
  int fail_count = 0;
  int total_checks = 0;
  tmfc_top tmfc_top_inst (.clk_sys_i, .rst_n_i, .standby_i, .bus_req_i, .bus_rdata_o,
    .quad_input_a_i, .quad_input_b_i, .count_tick_i, .ch2_run_i, .ch2_clear_i, .match_a_i,
    .match_b_i, .ch34_running_i, .sync_ch3_i, .sync_ch4_i, .pwm_pin_o, .cfg_o,
    .channel2_counter_o, .count_dir_o, .irq_o);
  tmfc_encoder_model tmfc_encoder_model_inst (.clk_sys_i, .up_i(step_up), .dn_i(step_dn),
    .quad_a_o(quad_input_a_i), .quad_b_o(quad_input_b_i));
  always #12.5 clk_sys_i = ~clk_sys_i;
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk_sys_i);
    bus_req_i <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys_i);
    bus_req_i.wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [15:0] exp, input string what);
    @(posedge clk_sys_i);
    bus_req_i <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys_i);
    bus_req_i.rd <= 1'b0;
    #1;
    chk(what, exp, {8'h00, bus_rdata_o});
  endtask
  task automatic mpulse(input logic a, input int i);
    @(posedge clk_sys_i);
    if (a)
      match_a_i <= 5'(1 << i);
    else
      match_b_i <= 5'(1 << i);
    @(posedge clk_sys_i);
    match_a_i <= 5'h00;
    match_b_i <= 5'h00;
    #1;
  endtask
  task automatic ticks(input int n);
    @(posedge clk_sys_i);
    count_tick_i <= 1'b1;
    repeat (n) @(posedge clk_sys_i);
    count_tick_i <= 1'b0;
    #1;
  endtask
  // decoder pipeline is a few cycles, so wait well past it
  task automatic step(input logic up, input logic [15:0] exp);
    @(posedge clk_sys_i);
    step_up <= up;
    step_dn <= !up;
    @(posedge clk_sys_i);
    step_up <= 1'b0;
    step_dn <= 1'b0;
    cyc(8);
    chk("counter", exp, channel2_counter_o);
    chk("direction", {15'h0000, !up}, {15'h0000, count_dir_o});
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (80000) @(posedge clk_sys_i);
    fail_count++;
    print_verdict();
  end
  initial begin
    repeat (5) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    rd(TMFC_OFF_MODE, 16'h0000, "mode reset");
    rd(TMFC_OFF_FUNC, 16'h0040, "func reset");
    rd(3'h6, 16'h0000, "unmapped");
    $display("test reset done");
    wr(TMFC_OFF_MODE, 8'hFF);
    rd(TMFC_OFF_MODE, 16'h00FF, "mode rw");
    for (int i = 0; i < 4; i++) begin
      wr(TMFC_OFF_FUNC, 8'hC0 | 8'(1 << i));
      cyc(2);
      chk("buffer enable", 16'(1 << i), 16'(cfg_o.buffer_en));
    end
    rd(TMFC_OFF_FUNC, 16'h00C8, "func rw");
    $display("test registers done");
    wr(TMFC_OFF_MODE, 8'h18);
    for (int c = 0; c < 4; c++) begin
      wr(TMFC_OFF_FUNC, 8'h40 | 8'(c << 4));
      cyc(2);
      chk("pwm ch3 ch4", (c > 1) ? 16'h0000 : 16'h0003, 16'(cfg_o.pwm_active[4:3]));
      chk("combined", 16'(c > 1 ? 4 - c : 0), {14'h0, cfg_o.comp_pwm, cfg_o.reset_sync_pwm});
    end
    $display("test combined done");
    wr(TMFC_OFF_FUNC, 8'h40);
    wr(TMFC_OFF_MODE, 8'h1F);
    cyc(2);
    for (int i = 0; i < 5; i++) begin
      mpulse(1'b1, i);
      chk("pwm set", 16'(1 << i), 16'(pwm_pin_o));
      mpulse(1'b0, i);
      chk("pwm clear", 16'h0000, 16'(pwm_pin_o));
    end
    wr(TMFC_OFF_FUNC, 8'h60);
    wr(TMFC_OFF_MODE, 8'h18);
    mpulse(1'b1, 3);
    chk("pwm overridden", 16'h0000, 16'(pwm_pin_o));
    wr(TMFC_OFF_FUNC, 8'h40);
    wr(TMFC_OFF_MODE, 8'h00);
    mpulse(1'b1, 0);
    chk("pwm off", 16'h0000, 16'(pwm_pin_o));
    $display("test pwm done");
    wr(TMFC_OFF_MASK, 8'h01);
    wr(TMFC_OFF_MODE, 8'h40);
    ch2_run_i <= 1'b1;
    ticks(4);
    chk("tick in phase mode", 16'h0000, channel2_counter_o);
    for (int i = 1; i <= 4; i++) step(1'b1, 16'(i));
    for (int i = 3; i >= 0; i--) step(1'b0, 16'(i));
    chk("irq idle", 16'h0000, 16'(irq_o));
    step(1'b0, 16'hFFFF);
    chk("irq underflow", 16'h0001, 16'(irq_o));
    rd(TMFC_OFF_CNT_LO, 16'h00FF, "counter low");
    rd(TMFC_OFF_STAT, 16'h0001, "underflow wrap");
    chk("irq cleared", 16'h0000, 16'(irq_o));
    wr(TMFC_OFF_MODE, 8'h60);
    cyc(2);
    step(1'b1, 16'h0000);
    rd(TMFC_OFF_STAT, 16'h0001, "overflow wrap");
    step(1'b0, 16'hFFFF);
    rd(TMFC_OFF_STAT, 16'h0000, "underflow ignored");
    @(posedge clk_sys_i);
    ch2_clear_i <= 1'b1;
    @(posedge clk_sys_i);
    ch2_clear_i <= 1'b0;
    #1;
    chk("clear in phase mode", 16'h0000, channel2_counter_o);
    $display("test quadrature done");
    wr(TMFC_OFF_MASK, 8'h00);
    wr(TMFC_OFF_MODE, 8'h20);
    cyc(2);
    ticks(3);
    chk("normal count", 16'h0003, channel2_counter_o);
    ticks(65533);
    chk("normal overflow", 16'h0000, channel2_counter_o);
    chk("irq masked", 16'h0000, 16'(irq_o));
    rd(TMFC_OFF_STAT, 16'h0001, "normal wrap");
    $display("test normal done");
    wr(TMFC_OFF_MODE, 8'hFF);
    wr(TMFC_OFF_FUNC, 8'hFF);
    @(posedge clk_sys_i);
    standby_i <= 1'b1;
    @(posedge clk_sys_i);
    standby_i <= 1'b0;
    rd(TMFC_OFF_MODE, 16'h0000, "mode standby");
    rd(TMFC_OFF_FUNC, 16'h0040, "func standby");
    $display("test standby done");
    // deliberately break the software rules to see the warning bits
    ch34_running_i <= 1'b1;
    wr(TMFC_OFF_FUNC, 8'h60);
    ch34_running_i <= 1'b0;
    rd(TMFC_OFF_STAT, 16'h0004, "combined while running");
    sync_ch3_i <= 1'b1;
    sync_ch4_i <= 1'b1;
    cyc(1);
    rd(TMFC_OFF_STAT, 16'h0008, "sync conflict");
    sync_ch3_i <= 1'b0;
    sync_ch4_i <= 1'b0;
    wr(TMFC_OFF_FUNC, 8'h40);
    cyc(1);
    rd(TMFC_OFF_STAT, 16'h0008, "sync conflict tail");
    rd(TMFC_OFF_STAT, 16'h0000, "warnings cleared");
    $display("test warnings done");
    print_verdict();
  end
endmodule
bind tmfc_top tmfc_assertions tmfc_assertions_inst (.clk_sys_i, .rst_n_i, .standby_i,
  .bus_req_i, .bus_rdata_o, .count_tick_i, .ch2_run_i, .ch2_clear_i, .match_a_i,
  .match_b_i, .pwm_pin_o, .cfg_o, .channel2_counter_o);
